// [src/nfi_top.sv]
// Network fault insertion channels with experiment sync and timers.
//
// Notes on behaviour
// [RULE_01] Eight physical channels, each breaking one network link between in and out.
// [RULE_02] Each physical channel maps to a logical channel; faults are set per logical.
// [RULE_03] Failing a logical channel fails all its physical channels together, same mode.
// [RULE_04] Normal mode passes the channel input straight to the output.
// [RULE_05] Passive mode holds the output low.
// [RULE_06] Active mode holds the output high.
// [RULE_07] Each connector indicator: green normal, dark passive, red active.
// [RULE_08] The chosen mode applies equally to the in and out connectors.
// [RULE_09] Drive a host ready sync output to the processor under test.
// [RULE_10] The processor's sync input gates all experiment timekeeping.
// [RULE_11] Each sync signal has an indicator: red for stop, green for run.
// [RULE_12] One timebase for all timekeeping, local or external selectable.
// [RULE_13] With external timebase selected, the processor supplies the timebase clock.
// [RULE_14] Timebase, sync and control go out on the experiment bus lines.
// [RULE_15] Timing is aligned with simulators and the system under test.
// [RULE_16] One timer counts experiment time, a second delays fault insertion.
// [RULE_17] Both timers are 24 bits wide.
// [RULE_18] Pending modes apply when the delay timer expires; reset leaves all normal.
// [RULE_19] Map and mode storage are host written and act on timebase ticks; map writes take effect on the next mclk edge, without a tick.
`include "nfi_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module nfi_top #(
	parameter int NPHYS = `NFI_NUM_PHYS,
	parameter int NLOG = `NFI_NUM_LOG,
	parameter int LW = `NFI_LOG_W,
	parameter int TW = `NFI_TIMER_W,
	parameter int TB_DIV = `NFI_LOCAL_TB_DIV
) (
	input wire logic mclk,
	input wire logic resetn,
	// Network link pins, in connector side and out connector side
	input wire logic [NPHYS-1:0] link_a_in,
	input wire logic [NPHYS-1:0] link_b_in,
	output logic [NPHYS-1:0] link_a_out,
	output logic [NPHYS-1:0] link_b_out,
	// Indicators, one bit per colour
	output logic [NPHYS-1:0] led_a_green,
	output logic [NPHYS-1:0] led_a_red,
	output logic [NPHYS-1:0] led_b_green,
	output logic [NPHYS-1:0] led_b_red,
	// Host control
	input wire logic map_we,
	input wire logic [LW-1:0] map_phys,
	input wire logic [LW-1:0] map_log,
	input wire logic mode_we,
	input wire logic [LW-1:0] mode_log,
	input wire logic [1:0] mode_val,
	input wire logic [TW-1:0] delay_load,
	input wire logic host_ready,
	input wire logic tb_ext_sel,
	input wire logic exp_clear,
	// Processor under test
	input wire logic put_sync_in,
	input wire logic put_timebase_in,
	output logic host_ready_sync,
	output logic led_hrs_green,
	output logic led_hrs_red,
	output logic led_put_green,
	output logic led_put_red,
	// Experiment bus
	output logic xbus_tick,
	output logic xbus_sync,
	output logic xbus_run,
	// Status
	output logic [TW-1:0] exp_time,
	output logic [TW-1:0] delay_time,
	output logic fault_pending,
	output logic fault_applied
);

	// ==========================================================
	// State
	// ==========================================================
	typedef struct packed {
		logic [NPHYS-1:0] a_s1;
		logic [NPHYS-1:0] a_s2;
		logic [NPHYS-1:0] b_s1;
		logic [NPHYS-1:0] b_s2;
		logic sync_s1;
		logic sync_s2;
		logic tb_s1;
		logic tb_s2;
		logic tb_d;
		logic [7:0] div;
		logic tick;
		logic [NPHYS-1:0][LW-1:0] map;
		logic [NLOG-1:0][1:0] mode_pend;
		logic [NLOG-1:0][1:0] mode_act;
		logic [TW-1:0] exp_t;
		logic [TW-1:0] dly_t;
		nfi_pkg::nfi_state_t st;
		logic [NPHYS-1:0] a_o;
		logic [NPHYS-1:0] b_o;
		logic [NPHYS-1:0] ag;
		logic [NPHYS-1:0] ar;
		logic [NPHYS-1:0] bg;
		logic [NPHYS-1:0] br;
		logic hrs;
		logic applied;
	} nfi_state_s_t;

	nfi_state_s_t s_reg;
	nfi_state_s_t s_next;

	// Output level of one channel for its mode
	function automatic logic nfi_drive(input logic [1:0] m, input logic d);
		case (m)
			nfi_pkg::NFI_PASSIVE: nfi_drive = 1'b0; // RULE_05
			nfi_pkg::NFI_ACTIVE: nfi_drive = 1'b1; // RULE_06
			default: nfi_drive = d; // RULE_04
		endcase
	endfunction : nfi_drive

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		logic [1:0] m;
		logic run;
		m = 2'h0;
		run = 1'b0;
		s_next = s_reg;
		// Two-flop synchronisers on the link, sync and timebase inputs
		s_next.a_s1 = link_a_in;
		s_next.a_s2 = s_reg.a_s1;
		s_next.b_s1 = link_b_in;
		s_next.b_s2 = s_reg.b_s1;
		s_next.sync_s1 = put_sync_in;
		s_next.sync_s2 = s_reg.sync_s1;
		s_next.tb_s1 = put_timebase_in;
		s_next.tb_s2 = s_reg.tb_s1;
		s_next.tb_d = s_reg.tb_s2;
		// Common timebase tick, local divider or external edge
		s_next.tick = 1'b0;
		if (s_reg.div >= 8'(TB_DIV - 1)) begin
			s_next.div = 8'h00;
		end else begin
			s_next.div = s_reg.div + 8'h01;
		end
		if (tb_ext_sel) begin // RULE_12 RULE_13
			s_next.tick = s_reg.tb_s2 & ~s_reg.tb_d;
		end else begin
			s_next.tick = (s_reg.div == 8'(TB_DIV - 1)); // RULE_12
		end
		run = s_reg.sync_s2;
		// Host writes to control storage
		if (map_we) begin // RULE_02 RULE_19
			s_next.map[map_phys] = map_log;
		end
		if (mode_we) begin // RULE_19
			s_next.mode_pend[mode_log] = mode_val;
			if (s_reg.st == nfi_pkg::NFI_ST_IDLE ||
			    s_reg.st == nfi_pkg::NFI_ST_APPLY) begin
				s_next.st = nfi_pkg::NFI_ST_DELAY;
				s_next.dly_t = delay_load;
				s_next.applied = 1'b0;
			end
		end
		// Timers advance only on timebase ticks while sync says run
		if (exp_clear) begin
			s_next.exp_t = '0;
		end else if (s_reg.tick && run) begin // RULE_10 RULE_16 RULE_17
			s_next.exp_t = s_reg.exp_t + 1'b1;
		end
		case (s_reg.st)
			nfi_pkg::NFI_ST_IDLE: begin
			end
			nfi_pkg::NFI_ST_DELAY: begin
				if (s_reg.tick && run) begin // RULE_16 RULE_19
					if (s_reg.dly_t == '0) begin
						s_next.mode_act = s_next.mode_pend; // RULE_18 RULE_03
						s_next.st = nfi_pkg::NFI_ST_APPLY;
						s_next.applied = 1'b1;
					end else if (!mode_we) begin
						s_next.dly_t = s_reg.dly_t - 1'b1;
					end
				end
			end
			nfi_pkg::NFI_ST_APPLY: begin
			end
			default: begin
				s_next.st = nfi_pkg::NFI_ST_IDLE;
			end
		endcase
		// Channel outputs and indicators, same mode on both sides
		for (int i = 0; i < NPHYS; i++) begin
			m = s_reg.mode_act[s_reg.map[i]]; // RULE_03
			s_next.a_o[i] = nfi_drive(m, s_reg.a_s2[i]); // RULE_01 RULE_08
			s_next.b_o[i] = nfi_drive(m, s_reg.b_s2[i]); // RULE_08
			// Code 3 passes data like normal, so it must also light green
			s_next.ag[i] = (m != nfi_pkg::NFI_PASSIVE) &&
				(m != nfi_pkg::NFI_ACTIVE); // RULE_07
			s_next.ar[i] = (m == nfi_pkg::NFI_ACTIVE); // RULE_07
			s_next.bg[i] = (m != nfi_pkg::NFI_PASSIVE) &&
				(m != nfi_pkg::NFI_ACTIVE); // RULE_07
			s_next.br[i] = (m == nfi_pkg::NFI_ACTIVE); // RULE_07
		end
		s_next.hrs = host_ready; // RULE_09
		if (!resetn) begin
			s_next = '0;
			s_next.st = nfi_pkg::NFI_ST_IDLE;
			for (int j = 0; j < NLOG; j++) begin
				s_next.mode_pend[j] = `NFI_MODE_RESET; // RULE_18
				s_next.mode_act[j] = `NFI_MODE_RESET; // RULE_18
			end
			for (int k = 0; k < NPHYS; k++) begin
				s_next.map[k] = `NFI_MAP_RESET;
			end
		end
	end

	always_ff @(posedge mclk) begin
		s_reg <= s_next;
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign link_a_out = s_reg.a_o;
	assign link_b_out = s_reg.b_o;
	assign led_a_green = s_reg.ag;
	assign led_a_red = s_reg.ar;
	assign led_b_green = s_reg.bg;
	assign led_b_red = s_reg.br;
	assign host_ready_sync = s_reg.hrs;
	assign led_hrs_green = s_reg.hrs; // RULE_11
	assign led_hrs_red = ~s_reg.hrs; // RULE_11
	assign led_put_green = s_reg.sync_s2; // RULE_11
	assign led_put_red = ~s_reg.sync_s2; // RULE_11
	assign xbus_tick = s_reg.tick; // RULE_14 RULE_15
	assign xbus_sync = s_reg.sync_s2; // RULE_14
	assign xbus_run = s_reg.hrs; // RULE_14
	assign exp_time = s_reg.exp_t;
	assign delay_time = s_reg.dly_t;
	assign fault_pending = (s_reg.st == nfi_pkg::NFI_ST_DELAY);
	assign fault_applied = s_reg.applied;

endmodule : nfi_top

`default_nettype wire

// [src/nfi_cfg.svh]
// Constants of the network fault injector.
`ifndef NFI_CFG_SVH
`define NFI_CFG_SVH
`define NFI_NUM_PHYS 8
`define NFI_NUM_LOG 8
`define NFI_LOG_W 3
`define NFI_TIMER_W 24
`define NFI_LOCAL_TB_DIV 25
`define NFI_MODE_RESET 2'h0
`define NFI_MAP_RESET 3'h0
`endif

// [src/nfi_pkg.sv]
// Types of the network fault injector.
package nfi_pkg;
	typedef enum logic [1:0] {
		NFI_NORMAL = 2'h0,
		NFI_PASSIVE = 2'h1,
		NFI_ACTIVE = 2'h2
	} nfi_mode_t;
	typedef enum logic [2:0] {
		NFI_ST_IDLE = 3'h1,
		NFI_ST_DELAY = 3'h2,
		NFI_ST_APPLY = 3'h4
	} nfi_state_t;
endpackage : nfi_pkg

// [tb/nfi_put_model.sv]
// Processor under test model: run/stop sync and external timebase.
`timescale 1ns/1ps
`default_nettype none
module nfi_put_model (
	input wire logic mclk,
	input wire logic run,
	output logic put_sync,
	output logic put_tb
);
	logic [1:0] div_reg = 2'h0;
	initial begin
		put_sync = 1'b0;
		put_tb = 1'b0;
	end
	always @(posedge mclk) begin
		div_reg <= div_reg + 2'h1;
		put_tb <= div_reg[1];
		put_sync <= run;
	end
endmodule : nfi_put_model
`default_nettype wire

// [tb/nfi_top_chk.sv]
// Port checks of the network fault injector.
`timescale 1ns/1ps
`default_nettype none
module nfi_top_chk #(
	parameter int NPHYS = 8
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic host_ready,
	input wire logic host_ready_sync,
	input wire logic mode_we,
	input wire logic fault_pending,
	input wire logic fault_applied,
	input wire logic led_hrs_green,
	input wire logic led_hrs_red,
	input wire logic [NPHYS-1:0] link_a_in,
	input wire logic [NPHYS-1:0] link_a_out,
	input wire logic [NPHYS-1:0] led_a_green,
	input wire logic [NPHYS-1:0] led_a_red,
	input wire logic [NPHYS-1:0] led_b_green,
	input wire logic [NPHYS-1:0] led_b_red
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	a_hrs_follow: assert property (
		$past(resetn) |-> host_ready_sync == $past(host_ready)) else $error("hrs");
	a_led_excl: assert property (
		!(|(led_a_green & led_a_red))) else $error("led both");
	a_led_sides: assert property (
		led_a_green == led_b_green && led_a_red == led_b_red) else $error("sides");
	a_out_active: assert property (
		(link_a_out & led_a_red) == led_a_red) else $error("active");
	a_out_passive: assert property (
		!(|(link_a_out & ~(led_a_green | led_a_red)))) else $error("passive");
	a_out_normal: assert property (
		$past(resetn, 3) |-> !(|((link_a_out ^ $past(link_a_in, 3)) & led_a_green)))
		else $error("normal");
	a_we_pending: assert property (
		mode_we && !fault_pending |=> fault_pending && !fault_applied)
		else $error("pending");
	a_sync_led: assert property (
		led_hrs_green != led_hrs_red) else $error("sync led");
endmodule : nfi_top_chk
bind nfi_top nfi_top_chk #(.NPHYS(NPHYS)) u_chk (.mclk(mclk), .resetn(resetn),
	.host_ready(host_ready), .host_ready_sync(host_ready_sync),
	.mode_we(mode_we), .fault_pending(fault_pending),
	.fault_applied(fault_applied), .led_hrs_green(led_hrs_green),
	.led_hrs_red(led_hrs_red), .link_a_in(link_a_in), .link_a_out(link_a_out),
	.led_a_green(led_a_green), .led_a_red(led_a_red),
	.led_b_green(led_b_green), .led_b_red(led_b_red));
`default_nettype wire

// [tb/nfi_top_tb.sv]
// Self-checking testbench for the network fault injector.
`timescale 1ns/1ps
`default_nettype none
module nfi_top_tb;
	logic mclk = 1'b0, resetn = 1'b0, map_we = 1'b0, mode_we = 1'b0;
	logic host_ready = 1'b0, tb_ext_sel = 1'b0, exp_clear = 1'b0, run = 1'b0;
	logic put_sync, put_tb, hrs, lhg, lhr, xrun, pend, appl, lpg, lpr, xsync;
	logic [23:0] dtime;
	logic [2:0] map_phys = 3'h0, map_log = 3'h0, mode_log = 3'h0;
	logic [1:0] mode_val = 2'h0;
	logic [23:0] delay_load = 24'h0, exp_time;
	logic [7:0] a_in = 8'h00, b_in = 8'h00, a_out, b_out, ag, ar, bg, br;
	logic [2:0] mp [8];
	logic [1:0] md [8];
	int seed = 83, miscompares = 0, cmp_count = 0;
	nfi_top #(.TB_DIV(2)) DUT (.mclk(mclk), .resetn(resetn), .link_a_in(a_in),
		.link_b_in(b_in), .link_a_out(a_out), .link_b_out(b_out),
		.led_a_green(ag), .led_a_red(ar), .led_b_green(bg), .led_b_red(br),
		.map_we(map_we), .map_phys(map_phys), .map_log(map_log),
		.mode_we(mode_we), .mode_log(mode_log), .mode_val(mode_val),
		.delay_load(delay_load), .host_ready(host_ready),
		.tb_ext_sel(tb_ext_sel), .exp_clear(exp_clear), .put_sync_in(put_sync),
		.put_timebase_in(put_tb), .host_ready_sync(hrs), .led_hrs_green(lhg),
		.led_hrs_red(lhr), .led_put_green(lpg), .led_put_red(lpr),
		.xbus_tick(), .xbus_sync(xsync), .xbus_run(xrun),
		.exp_time(exp_time), .delay_time(dtime),
		.fault_pending(pend), .fault_applied(appl));
	nfi_put_model u_put (.mclk(mclk), .run(run), .put_sync(put_sync),
		.put_tb(put_tb));
	always #20 mclk = ~mclk;
	task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : step
	function automatic logic [7:0] expv(input logic [7:0] din, input int k);
		logic [1:0] m;
		for (int p = 0; p < 8; p++) begin
			m = md[mp[p]];
			expv[p] = k == 0 ? (m == 2'h1 ? 1'b0 : m == 2'h2 ? 1'b1 : din[p]) :
				k == 1 ? (m == 2'h0 || m == 2'h3) : (m == 2'h2);
		end
	endfunction : expv
	task automatic round(input logic ext, input logic [23:0] dly);
		int n;
		tb_ext_sel = ext;
		host_ready = $random(seed);
		a_in = $random(seed);
		b_in = $random(seed);
		for (int i = 0; i < 16; i++) begin
			map_we = i < 8;
			mode_we = i >= 8;
			map_phys = i[2:0];
			mode_log = i[2:0];
			map_log = $random(seed);
			mode_val = $random(seed);
			delay_load = dly;
			if (i < 8) mp[i] = map_log;
			else md[i-8] = mode_val;
			step(1);
		end
		mode_we = 1'b0;
		n = 0;
		while (appl !== 1'b1 && n < 400) begin
			step(1);
			n++;
		end
		cmp(n < 400, 24'h1);
		step(2);
		cmp(a_out, expv(a_in, 0));
		cmp(b_out, expv(b_in, 0));
		cmp(ag, expv(a_in, 1));
		cmp(br, expv(b_in, 2));
		cmp(ar, expv(a_in, 2));
		cmp(bg, expv(b_in, 1));
		cmp({lhg, lhr, lpg, lpr}, {host_ready, ~host_ready, run, ~run});
		cmp(xsync, run);
		cmp(dtime, 24'h0);
		cmp({hrs, xrun}, {2{host_ready}});
	endtask : round
	task automatic test_done;
		$display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : test_done
	initial begin
		step(10);
		cmp({a_out, b_out, hrs}, 24'h0);
		resetn = 1'b1;
		step(3);
		cmp({ag, bg}, 24'hffff);
		exp_clear = 1'b1;
		mode_we = 1'b1;
		step(1);
		exp_clear = 1'b0;
		mode_we = 1'b0;
		step(40);
		cmp({pend, appl}, 24'h2);
		cmp(exp_time, 24'h0);
		run = 1'b1;
		step(30);
		cmp(exp_time != 24'h0, 24'h1);
		for (int k = 0; k < 8; k++) round(k[0], {21'h0, 3'($random(seed))});
		test_done;
	end
	// Run needs under 500 cycles; 5000 leaves a wide margin
	initial begin
		#200000;
		miscompares++;
		test_done;
	end
endmodule : nfi_top_tb
`default_nettype wire
